// File: inc/mpu_params.svh
/*
 * Constants of the motor PWM interrupt routing block: register indices,
 * reset values, field positions and bus response codes.
 * Assumes it is included by bare name from the design and the bench.
 */
`ifndef MPU_PARAMS_SVH
`define MPU_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define MPU_IDX_NODE_PTR   16'hE8D6
`define MPU_IDX_ENABLE     16'hE8D8
`define MPU_IDX_SUSPEND    16'hE8DA
`define MPU_IDX_CHAN_NC    16'hF140
`define MPU_IDX_ERR_NC     16'hF188
`define MPU_IDX_PRI_NC     16'hF190
`define MPU_IDX_SEC_NC     16'hF198

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define MPU_NODE_PTR_RST   16'h3940
`define MPU_NODE_PTR_MASK  16'h3FFF
`define MPU_ENABLE_MASK    16'h7FFF
`define MPU_SUSP_MASK      16'h0001

// ----------------------------------------------------------------------
// Field positions and source count
// ----------------------------------------------------------------------
`define MPU_BIT_IDLE_EN    14
`define MPU_BIT_WRONG      13
`define MPU_BIT_SEC_PM     9
`define MPU_NUM_SRC        14
`define MPU_SUSP_EN_BIT    0
`define MPU_SUSP_ST_BIT    1

// ----------------------------------------------------------------------
// AXI4-Lite responses
// ----------------------------------------------------------------------
`define MPU_RESP_OKAY      2'h0
`define MPU_RESP_SLVERR    2'h2

`endif

// File: inc/mpu_pkg.sv
/*
 * Types of the motor PWM interrupt routing block.
 * Stands alone; it does not include the constants header.
 */
`default_nettype none
package mpu_pkg;

	// ------------------------------------------------------------------
	// Whole state of the routing block
	// ------------------------------------------------------------------
	typedef struct packed {
		logic             sync1;
		logic             sync2;
		logic             suspended;
		logic             kclk_en;
		logic             susp_en;
		logic [15:0]      enable;
		logic [15:0]      node_ptr;
		logic [3:0][15:0] node_ctl;
		logic             aw_got;
		logic [17:0]      awaddr;
		logic             w_got;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             awready;
		logic             wready;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             arready;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
		logic [3:0]       irq;
		logic             sec_pm;
		logic             idle_set;
	} mpu_state_t;

endpackage
`default_nettype wire

// File: hdl/mpu_irq_route.sv
/*
 * Interrupt enable, node routing and suspend control of the motor PWM
 * unit, reached over AXI4-Lite.
 * Assumes event pulses come from logic on I_CLK; the suspend request
 * arrives from another domain and is synchronised here.
 */
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "mpu_params.svh"

module mpu_irq_route
	import mpu_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic [15:0] I_EVENT,
	input  wire logic        I_SUSPEND_REQ,
	input  wire logic        I_SAFE_STATE,
	input  wire logic [17:0] I_AWADDR,
	input  wire logic        I_AWVALID,
	output var  logic        O_AWREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	input  wire logic        I_WVALID,
	output var  logic        O_WREADY,
	output var  logic [1:0]  O_BRESP,
	output var  logic        O_BVALID,
	input  wire logic        I_BREADY,
	input  wire logic [17:0] I_ARADDR,
	input  wire logic        I_ARVALID,
	output var  logic        O_ARREADY,
	output var  logic [31:0] O_RDATA,
	output var  logic [1:0]  O_RRESP,
	output var  logic        O_RVALID,
	input  wire logic        I_RREADY,
	output var  logic [3:0]  O_IRQ,
	output var  logic        O_SEC_PERIOD_PULSE,
	output var  logic        O_IDLE_SET,
	output var  logic        O_KERNEL_CLK_EN
);

	mpu_state_t st;
	mpu_state_t next_st;

	// ------------------------------------------------------------------
	// Source to pointer field map
	// ------------------------------------------------------------------
	function automatic logic [2:0] src_field(input int src);
		logic [2:0] f;
		f = 3'h0;
		case (src)
			0, 1:   f = 3'h0;
			2, 3:   f = 3'h1;
			4, 5:   f = 3'h2;
			11, 12: f = 3'h3;
			10, 13: f = 3'h4;
			6, 7:   f = 3'h5;
			8, 9:   f = 3'h6;
			default: f = 3'h0;
		endcase
		return f;
	endfunction

	// Byte-lane merge of a 16-bit register; reserved bits stay zero.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb,
		input logic [15:0] mask);
		logic [15:0] v;
		v = old;
		if (strb[0]) begin
			v[7:0] = data[7:0];
		end
		if (strb[1]) begin
			v[15:8] = data[15:8];
		end
		return v & mask;
	endfunction

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		logic [15:0] widx;
		logic [15:0] ridx;
		logic [2:0]  fld;
		logic [1:0]  line;
		widx = st.awaddr[17:2];
		ridx = I_ARADDR[17:2];
		fld = 3'h0;
		line = 2'h0;
		next_st = st;

		next_st.sync1 = I_SUSPEND_REQ;
		next_st.sync2 = st.sync1;

		// Suspend is left as soon as the synchronised request drops; no register
		// is touched on either edge of it.
		if (st.suspended) begin
			if (!st.sync2) begin
				next_st.suspended = 1'b0;
			end
		end else if (st.sync2 && st.susp_en && I_SAFE_STATE) begin
			next_st.suspended = 1'b1;
		end
		next_st.kclk_en = !next_st.suspended;

		// Each enabled event pulses the line its field selects; several
		// sources on one line in one cycle merge into one pulse.
		next_st.irq = 4'h0;
		for (int i = 0; i < `MPU_NUM_SRC; i++) begin
			if (I_EVENT[i] && st.enable[i]) begin
				fld = src_field(i);
				line = st.node_ptr[fld*2 +: 2];
				next_st.irq[line] = 1'b1;
			end
		end
		next_st.idle_set = I_EVENT[`MPU_BIT_WRONG]
			&& st.enable[`MPU_BIT_IDLE_EN];
		next_st.sec_pm = I_EVENT[`MPU_BIT_SEC_PM];

		// Write channel: address and data are taken in either order.
		if (st.bvalid && I_BREADY) begin
			next_st.bvalid = 1'b0;
		end
		if (st.awready && I_AWVALID) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = I_AWADDR;
		end
		if (st.wready && I_WVALID) begin
			next_st.w_got = 1'b1;
			next_st.wdata = I_WDATA;
			next_st.wstrb = I_WSTRB;
		end
		if (st.aw_got && st.w_got && !st.bvalid) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `MPU_RESP_OKAY;
			// A suspended unit answers but keeps every bit as it was.
			unique case (widx)
				`MPU_IDX_NODE_PTR: if (!st.suspended) begin
					next_st.node_ptr = merge16(st.node_ptr, st.wdata,
						st.wstrb, `MPU_NODE_PTR_MASK);
				end
				`MPU_IDX_ENABLE: if (!st.suspended) begin
					next_st.enable = merge16(st.enable, st.wdata,
						st.wstrb, `MPU_ENABLE_MASK);
				end
				`MPU_IDX_SUSPEND: if (!st.suspended && st.wstrb[0]) begin
					next_st.susp_en = st.wdata[`MPU_SUSP_EN_BIT];
				end
				`MPU_IDX_CHAN_NC: if (!st.suspended) begin
					next_st.node_ctl[0] = merge16(st.node_ctl[0],
						st.wdata, st.wstrb, 16'hFFFF);
				end
				`MPU_IDX_ERR_NC: if (!st.suspended) begin
					next_st.node_ctl[1] = merge16(st.node_ctl[1],
						st.wdata, st.wstrb, 16'hFFFF);
				end
				`MPU_IDX_PRI_NC: if (!st.suspended) begin
					next_st.node_ctl[2] = merge16(st.node_ctl[2],
						st.wdata, st.wstrb, 16'hFFFF);
				end
				`MPU_IDX_SEC_NC: if (!st.suspended) begin
					next_st.node_ctl[3] = merge16(st.node_ctl[3],
						st.wdata, st.wstrb, 16'hFFFF);
				end
				default: begin
					next_st.bresp = `MPU_RESP_SLVERR;
				end
			endcase
		end
		next_st.awready = !next_st.aw_got && !next_st.bvalid;
		next_st.wready = !next_st.w_got && !next_st.bvalid;

		// Read channel: data one cycle after the address is taken.
		if (st.rvalid && I_RREADY) begin
			next_st.rvalid = 1'b0;
		end
		if (st.arready && I_ARVALID) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = `MPU_RESP_OKAY;
			next_st.rdata = 32'h0000_0000;
			unique case (ridx)
				`MPU_IDX_NODE_PTR: next_st.rdata[15:0] = st.node_ptr;
				`MPU_IDX_ENABLE:   next_st.rdata[15:0] = st.enable;
				`MPU_IDX_SUSPEND: begin
					next_st.rdata[`MPU_SUSP_EN_BIT] = st.susp_en;
					next_st.rdata[`MPU_SUSP_ST_BIT] = st.suspended;
				end
				`MPU_IDX_CHAN_NC:  next_st.rdata[15:0] = st.node_ctl[0];
				`MPU_IDX_ERR_NC:   next_st.rdata[15:0] = st.node_ctl[1];
				`MPU_IDX_PRI_NC:   next_st.rdata[15:0] = st.node_ctl[2];
				`MPU_IDX_SEC_NC:   next_st.rdata[15:0] = st.node_ctl[3];
				default: begin
					next_st.rresp = `MPU_RESP_SLVERR;
				end
			endcase
		end
		next_st.arready = !next_st.rvalid;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			st <= '0;
			st.node_ptr <= `MPU_NODE_PTR_RST;
			st.kclk_en <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign O_AWREADY          = st.awready;
	assign O_WREADY           = st.wready;
	assign O_BRESP            = st.bresp;
	assign O_BVALID           = st.bvalid;
	assign O_ARREADY          = st.arready;
	assign O_RDATA            = st.rdata;
	assign O_RRESP            = st.rresp;
	assign O_RVALID           = st.rvalid;
	assign O_IRQ              = st.irq;
	assign O_SEC_PERIOD_PULSE = st.sec_pm;
	assign O_IDLE_SET         = st.idle_set;
	assign O_KERNEL_CLK_EN    = st.kclk_en;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chan0_route_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_EVENT[0] && st.enable[0]) |=> O_IRQ[$past(st.node_ptr[1:0])])
		else $error("channel 0 event not routed to its line");

	sec_cm_route_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_EVENT[8] && st.enable[8]) |=> O_IRQ[$past(st.node_ptr[13:12])])
		else $error("secondary compare event not routed");

	gated_irq_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_EVENT[13:0] & st.enable[13:0]) == 14'h0000 |=> O_IRQ == 4'h0)
		else $error("request line pulsed without an enabled event");

	idle_set_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_EVENT[13] && !st.enable[14]) |=> !O_IDLE_SET)
		else $error("idle set without idle enable");

	sec_period_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_EVENT[9] |=> O_SEC_PERIOD_PULSE ##1
		(O_SEC_PERIOD_PULSE == $past(I_EVENT[9])))
		else $error("secondary period pulse not forwarded");

	ptr_reset_a: assert property (@(posedge I_CLK)
		$fell(I_RST) |-> st.node_ptr == `MPU_NODE_PTR_RST)
		else $error("node pointer reset value wrong");

	susp_write_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(st.suspended && next_st.suspended && st.aw_got && st.w_got
		&& !st.bvalid) |=> $stable(st.enable) && $stable(st.node_ptr))
		else $error("write took effect while suspended");

	susp_entry_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		$rose(st.suspended) |-> $past(st.sync2) && $past(st.susp_en)
		&& $past(I_SAFE_STATE))
		else $error("suspend entered without its conditions");

	susp_clock_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(!st.suspended && st.sync2 && st.susp_en && I_SAFE_STATE)
		|=> !O_KERNEL_CLK_EN ##1 (O_KERNEL_CLK_EN == !st.suspended))
		else $error("kernel clock not stopped on suspend");

	// A software write that completes in the entry cycle is allowed to land.
	susp_quiet_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		($rose(st.suspended) || $fell(st.suspended)) && !$rose(st.bvalid)
		|-> $stable(st.enable) && $stable(st.node_ptr))
		else $error("suspend transition changed a register");

	chan1_route_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_EVENT[3] && st.enable[3]) |=> O_IRQ[$past(st.node_ptr[3:2])])
		else $error("channel 1 event not routed to its line");

	chan2_route_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_EVENT[5] && st.enable[5]) |=> O_IRQ[$past(st.node_ptr[5:4])])
		else $error("channel 2 event not routed to its line");

	corr_route_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_EVENT[12] && st.enable[12]) |=> O_IRQ[$past(st.node_ptr[7:6])])
		else $error("correct pattern event not routed");

	shad_route_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_EVENT[11] && st.enable[11]) |=> O_IRQ[$past(st.node_ptr[7:6])])
		else $error("shadow transfer event not routed");

	emerg_route_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_EVENT[10] && st.enable[10]) |=> O_IRQ[$past(st.node_ptr[9:8])])
		else $error("emergency stop event not routed");

	pri_route_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_EVENT[7] && st.enable[7]) |=> O_IRQ[$past(st.node_ptr[11:10])])
		else $error("primary period event not routed");

	idle_enable_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(I_EVENT[13] && st.enable[14]) |=> O_IDLE_SET)
		else $error("idle set missing on wrong pattern");

	idle_quiet_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		!(I_EVENT[13] && st.enable[14]) |=> !O_IDLE_SET)
		else $error("idle set without its cause");

	period_quiet_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		!I_EVENT[9] |=> !O_SEC_PERIOD_PULSE)
		else $error("period pulse without period event");

	susp_guard_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(!st.suspended && !(st.sync2 && st.susp_en && I_SAFE_STATE))
		|=> !st.suspended)
		else $error("suspend entered while a condition was missing");

	susp_exit_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(st.suspended && !st.sync2) |=> O_KERNEL_CLK_EN)
		else $error("kernel clock not restarted after suspend");

	susp_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
		(st.suspended && st.arready && I_ARVALID) |=> O_RVALID)
		else $error("read not answered while suspended");

endmodule
`default_nettype wire

// File: verif/mpu_irq_sink.sv
/*
 * Model of the system interrupt control block: counts request pulses
 * on each of the four lines.
 * Assumes the lines are pulses on the same clock as the model.
 */
`timescale 1ns/1ps
`default_nettype none
module mpu_irq_sink (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [3:0]       i_irq,
	output var  logic [3:0][15:0] o_count
);
	// Every high cycle counts, so a pulse that lingers shows as extra.
	always_ff @(posedge i_clk) begin
		for (int k = 0; k < 4; k++) begin
			if (i_rst) begin
				o_count[k] <= 16'h0000;
			end else if (i_irq[k]) begin
				o_count[k] <= o_count[k] + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
/*
 * Bench of the interrupt routing block: AXI4-Lite tasks and tests of
 * gating, routing, reset values and suspend.
 * Assumes the package, the constants header and the request sink.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mpu_params.svh"
module tb_top
	import mpu_pkg::*;
;
	logic             I_CLK, I_RST, req, safe, awv, wv, bry, arv, rry;
	logic             awrdy, wrdy, bvld, arrdy, rvld, secp, idle, kclk;
	logic [15:0]      ev, ptr, rv;
	logic [17:0]      awa, ara;
	logic [31:0]      wd, rdt;
	logic [1:0]       brsp, rrsp, rs;
	logic [3:0]       irq, irq_s, ws;
	logic             sec_s, idle_s;
	logic [3:0][15:0] cnt;
	int               n_errors, comparisons, fl;
	int               exp_cnt [4];
	logic [15:0]      ptrs [5] = '{16'h3940, 16'h0000, 16'h1555,
		16'h2AAA, 16'hFFFF};
	logic [15:0]      ncs [4] = '{`MPU_IDX_CHAN_NC, `MPU_IDX_ERR_NC,
		`MPU_IDX_PRI_NC, `MPU_IDX_SEC_NC};

	mpu_irq_route i_mpu_irq_route (.I_CLK(I_CLK), .I_RST(I_RST),
		.I_EVENT(ev), .I_SUSPEND_REQ(req), .I_SAFE_STATE(safe),
		.I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awrdy),
		.I_WDATA(wd), .I_WSTRB(ws), .I_WVALID(wv), .O_WREADY(wrdy),
		.O_BRESP(brsp), .O_BVALID(bvld), .I_BREADY(bry),
		.I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arrdy),
		.O_RDATA(rdt), .O_RRESP(rrsp), .O_RVALID(rvld), .I_RREADY(rry),
		.O_IRQ(irq), .O_SEC_PERIOD_PULSE(secp), .O_IDLE_SET(idle),
		.O_KERNEL_CLK_EN(kclk));
	mpu_irq_sink i_mpu_irq_sink (.i_clk(I_CLK), .i_rst(I_RST),
		.i_irq(irq), .o_count(cnt));

	initial begin
		I_CLK = 1'b0;
		forever #50 I_CLK = ~I_CLK;
	end

	// ------------------------------------------------------------------
	// Report and compare tasks
	// ------------------------------------------------------------------
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic timeout;
		n_errors++;
		$display("unexpected at %0t: wait ran out", $time);
		stop_test();
	endtask
	task automatic chk(input logic [31:0] got, exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, exp);
		chk({30'h0, got}, {30'h0, exp}, "response");
	endtask

	// ------------------------------------------------------------------
	// Bus and event tasks
	// ------------------------------------------------------------------
	// Ready is sampled mid-cycle, so it is the value the next edge sees.
	task automatic wr(input logic [15:0] idx, d, output logic [1:0] r);
		logic a, w, b, done;
		done = 1'b0;
		@(posedge I_CLK);
		awa <= {idx, 2'b00};
		wd <= {16'h0000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		for (int n = 0; n < 40 && !done; n++) begin
			@(negedge I_CLK);
			a = awrdy;
			w = wrdy;
			b = bvld;
			r = brsp;
			@(posedge I_CLK);
			if (a) awv <= 1'b0;
			if (w) wv <= 1'b0;
			if (b) begin
				bry <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) timeout();
	endtask
	task automatic rd_chk(input logic [15:0] idx, exp, input logic [1:0] er);
		logic a, done;
		done = 1'b0;
		@(posedge I_CLK);
		ara <= {idx, 2'b00};
		arv <= 1'b1;
		rry <= 1'b1;
		for (int n = 0; n < 40 && !done; n++) begin
			@(negedge I_CLK);
			a = arrdy;
			done = rvld;
			rv = rdt[15:0];
			rs = rrsp;
			chk({16'h0000, rdt[31:16]}, 32'h0000_0000, "upper read data");
			@(posedge I_CLK);
			if (a) arv <= 1'b0;
			if (done) rry <= 1'b0;
		end
		if (!done) timeout();
		chk({16'h0000, rv}, {16'h0000, exp}, "read data");
		chk_resp(rs, er);
	endtask
	task automatic pulse(input int i);
		@(posedge I_CLK);
		ev <= 16'h0001 << i;
		@(posedge I_CLK);
		ev <= 16'h0000;
		#1;
		irq_s = irq;
		sec_s = secp;
		idle_s = idle;
	endtask
	task automatic wait_kclk(input logic e);
		int n;
		n = 0;
		while (kclk !== e && n < 40) begin
			@(posedge I_CLK);
			#1;
			n++;
		end
		if (kclk !== e) timeout();
	endtask
	function automatic int field_of(input int i);
		if (i < 6) return i / 2;
		if (i < 8) return 5;
		if (i < 10) return 6;
		if (i == 10 || i == 13) return 4;
		return 3;
	endfunction

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		{I_RST, req, safe, awv, wv, bry, arv, rry} = 8'h80;
		{ev, awa, ara, wd} = '0;
		ws = 4'h3;
		repeat (3) @(posedge I_CLK);
		I_RST <= 1'b0;
		rd_chk(`MPU_IDX_NODE_PTR, `MPU_NODE_PTR_RST, `MPU_RESP_OKAY);
		rd_chk(`MPU_IDX_ENABLE, 16'h0000, `MPU_RESP_OKAY);
		rd_chk(16'h0000, 16'h0000, `MPU_RESP_SLVERR);
		wr(16'h0000, 16'hFFFF, rs);
		chk_resp(rs, `MPU_RESP_SLVERR);
		for (int k = 0; k < 4; k++) begin
			rd_chk(ncs[k], 16'h0000, `MPU_RESP_OKAY);
			wr(ncs[k], 16'hA5C0 + 16'(k), rs);
			rd_chk(ncs[k], 16'hA5C0 + 16'(k), `MPU_RESP_OKAY);
		end
		ws <= 4'h1;
		wr(ncs[0], 16'h1234, rs);
		ws <= 4'hC;
		wr(ncs[1], 16'hFFFF, rs);
		ws <= 4'h3;
		rd_chk(ncs[0], 16'hA534, `MPU_RESP_OKAY);
		rd_chk(ncs[1], 16'hA5C1, `MPU_RESP_OKAY);
		$display("test registers done");
		for (int p = 0; p < 5; p++) begin
			ptr = ptrs[p] & `MPU_NODE_PTR_MASK;
			if (p > 0) wr(`MPU_IDX_NODE_PTR, ptrs[p], rs);
			rd_chk(`MPU_IDX_NODE_PTR, ptr, `MPU_RESP_OKAY);
			for (int i = 0; i < 14; i++) begin
				fl = 32'(ptr >> (2 * field_of(i))) & 3;
				wr(`MPU_IDX_ENABLE, `MPU_ENABLE_MASK & ~(16'h0001 << i), rs);
				pulse(i);
				chk({28'h0, irq_s}, 32'h0, "gated request");
				wr(`MPU_IDX_ENABLE, 16'h0001 << i, rs);
				pulse(i);
				chk({28'h0, irq_s}, 32'h1 << fl, "request line");
				exp_cnt[fl]++;
			end
		end
		$display("test routing done");
		wr(`MPU_IDX_ENABLE, 16'h4000, rs);
		pulse(13);
		chk({31'h0, idle_s}, 32'h1, "idle set");
		wr(`MPU_IDX_ENABLE, 16'h2000, rs);
		pulse(13);
		chk({31'h0, idle_s}, 32'h0, "idle set");
		exp_cnt[3]++;
		wr(`MPU_IDX_ENABLE, 16'h0000, rs);
		pulse(9);
		chk({31'h0, sec_s}, 32'h1, "period pulse");
		$display("test idle and period done");
		req <= 1'b1;
		safe <= 1'b1;
		repeat (10) @(posedge I_CLK);
		req <= 1'b0;
		#1;
		chk({31'h0, kclk}, 32'h1, "clock enable");
		wr(`MPU_IDX_ENABLE, 16'h0001, rs);
		wr(`MPU_IDX_SUSPEND, 16'h0001, rs);
		safe <= 1'b0;
		req <= 1'b1;
		repeat (10) @(posedge I_CLK);
		safe <= 1'b1;
		#1;
		chk({31'h0, kclk}, 32'h1, "clock enable");
		wait_kclk(1'b0);
		rd_chk(`MPU_IDX_SUSPEND, 16'h0003, `MPU_RESP_OKAY);
		wr(`MPU_IDX_ENABLE, 16'h1234, rs);
		chk_resp(rs, `MPU_RESP_OKAY);
		rd_chk(`MPU_IDX_ENABLE, 16'h0001, `MPU_RESP_OKAY);
		pulse(0);
		chk({28'h0, irq_s}, 32'h8, "request in suspend");
		exp_cnt[3]++;
		@(posedge I_CLK);
		req <= 1'b0;
		wait_kclk(1'b1);
		rd_chk(`MPU_IDX_ENABLE, 16'h0001, `MPU_RESP_OKAY);
		rd_chk(`MPU_IDX_NODE_PTR, 16'h3FFF, `MPU_RESP_OKAY);
		$display("test suspend done");
		for (int k = 0; k < 4; k++) begin
			chk({16'h0, cnt[k]}, 32'(exp_cnt[k]), "pulse count");
		end
		I_RST <= 1'b1;
		repeat (3) @(posedge I_CLK);
		I_RST <= 1'b0;
		rd_chk(`MPU_IDX_NODE_PTR, `MPU_NODE_PTR_RST, `MPU_RESP_OKAY);
		rd_chk(`MPU_IDX_ENABLE, 16'h0000, `MPU_RESP_OKAY);
		$display("test reset done");
		stop_test();
	end
endmodule
`default_nettype wire
